// File: plld_top.sv
`default_nettype none
module plld_top #(
   parameter int SWALLOW_W = plld_pkg::SWALLOW_W,
   parameter int MAIN_W = plld_pkg::MAIN_W,
   parameter int REF_W = plld_pkg::REF_W
) (
   // Clocking
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Signal inputs
   input wire logic rfIn,
   input wire logic refIn,
   input wire logic word_select,
   // Outputs
   output logic cpUp,
   output logic cpDown,
   output logic div_compare_pulse,
   output logic refComparePulse
);
   logic [31:0] word1;
   logic [31:0] word2;
   logic [31:0] refCfg;
   logic [REF_W-1:0] refBuf;
   logic [SWALLOW_W-1:0] activeA;
   logic [MAIN_W-1:0] activeM;
   logic [SWALLOW_W-1:0] swCnt;
   logic [MAIN_W-1:0] mainCnt;
   logic [4:0] psCnt;
   logic [REF_W-1:0] refCnt;
   logic rfPrev;
   logic refPrev;
   logic pfdUp;
   logic pfdDown;
   logic rfEdge;
   logic refEdge;
   logic swallowDone;
   logic [4:0] psLast;
   logic psPulse;
   logic endCycle;
   logic refEnd;
   logic [MAIN_W-1:0] remaining;
   logic [31:0] selWord;
   logic setupPh;
   logic writeHit;

   function automatic logic addrMapped(input logic [7:0] a);
      addrMapped = (a == plld_pkg::ADDR_WORD1) ||
         (a == plld_pkg::ADDR_WORD2) || (a == plld_pkg::ADDR_REFCFG) ||
         (a == plld_pkg::ADDR_STATUS);
   endfunction : addrMapped

   function automatic logic [31:0] readMux(input logic [7:0] a);
      readMux = 32'h0000_0000;
      case (a)
         plld_pkg::ADDR_WORD1: readMux = word1;
         plld_pkg::ADDR_WORD2: readMux = word2;
         plld_pkg::ADDR_REFCFG: readMux = refCfg;
         plld_pkg::ADDR_STATUS: begin
            readMux[plld_pkg::STAT_MAIN_LSB +: MAIN_W] = mainCnt;
            readMux[plld_pkg::STAT_SWALLOW_LSB +: SWALLOW_W] = swCnt;
            readMux[plld_pkg::STAT_SMALLMOD_BIT] = swallowDone;
         end
         default: readMux = 32'h0000_0000;
      endcase
   endfunction : readMux

   // APB: answer in the first cycle of the access phase, no wait state
   assign setupPh = psel && !penable;
   assign writeHit = psel && penable && pready && pwrite && !pslverr;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= setupPh;
         pslverr <= setupPh && !addrMapped(paddr);
         if (setupPh && !pwrite) begin
            prdata <= readMux(paddr);
         end
      end
   end

   // Only the divider and reference configuration fields are kept; other bits read zero
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         word1 <= plld_pkg::WORD_RST;
         word2 <= plld_pkg::WORD_RST;
         refCfg <= plld_pkg::REFCFG_RST;
      end else if (ce && writeHit) begin
         case (paddr)
            plld_pkg::ADDR_WORD1:
               word1 <= {13'h0000, pwdata[SWALLOW_W+MAIN_W-1:0]};
            plld_pkg::ADDR_WORD2:
               word2 <= {13'h0000, pwdata[SWALLOW_W+MAIN_W-1:0]};
            plld_pkg::ADDR_REFCFG: refCfg <= {16'h0000, pwdata[15:0]};
            default: ;
         endcase
      end
   end

   // Input edge detection
   assign rfEdge = rfIn && !rfPrev;
   assign refEdge = refIn && !refPrev;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rfPrev <= 1'b0;
         refPrev <= 1'b0;
      end else if (ce) begin
         rfPrev <= rfIn;
         refPrev <= refIn;
      end
   end

   // Dual-modulus prescaler
   assign swallowDone = (swCnt >= activeA);
   assign psLast = refCfg[plld_pkg::MODSEL_BIT] ?
      (swallowDone ? plld_pkg::MOD8_LAST : plld_pkg::MOD8_LAST + 5'h01) :
      (swallowDone ? plld_pkg::MOD16_LAST : plld_pkg::MOD16_LAST + 5'h01);
   assign psPulse = rfEdge && (activeM != '0) && (psCnt == psLast);
   // At or past the count, so a shortened word still ends the cycle
   assign endCycle = psPulse && (mainCnt >= activeM - 1'b1);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         psCnt <= 5'h00;
      end else if (ce && rfEdge && activeM != '0) begin
         psCnt <= (psCnt == psLast) ? 5'h00 : psCnt + 5'h01;
      end
   end

   // Swallow and main counters; A at N+1 then M-A at N gives MN+A
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         swCnt <= '0;
         mainCnt <= '0;
      end else if (ce && psPulse) begin
         if (endCycle) begin
            swCnt <= '0;
            mainCnt <= '0;
         end else begin
            if (!swallowDone) begin
               swCnt <= swCnt + 1'b1;
            end
            mainCnt <= mainCnt + 1'b1;
         end
      end
   end

   // Working word follows the selected buffer only with margin left or while activeM is zero,
   // so a word half way through a change never reaches the counters
   assign selWord = word_select ? word1 : word2;
   assign remaining = activeM - mainCnt;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         activeA <= '0;
         activeM <= '0;
      end else if (ce && (remaining > plld_pkg::MAIN_GUARD ||
            activeM == '0)) begin
         activeA <= selWord[plld_pkg::SWALLOW_LSB +: SWALLOW_W];
         activeM <= selWord[plld_pkg::MAIN_LSB +: MAIN_W];
      end
   end

   // Reference divider, reloads from its buffer; ratio 0 acts as 1
   assign refEnd = refEdge &&
      (refCnt + 1'b1 >= refBuf || refBuf == '0);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         refBuf <= '0;
         refCnt <= '0;
      end else if (ce) begin
         if (refEnd || refEdge == 1'b0 && refCnt == '0) begin
            refBuf <= refCfg[plld_pkg::RATIO_LSB +: REF_W];
         end
         if (refEnd) begin
            refCnt <= '0;
         end else if (refEdge) begin
            refCnt <= refCnt + 1'b1;
         end
      end
   end

   plld_pfd plld_pfd_inst (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .divPulse(endCycle),
      .refPulse(refEnd),
      .sense(refCfg[plld_pkg::SENSE_BIT]),
      .up(pfdUp),
      .down(pfdDown)
   );

   // Charge pump enable gates cpUp and cpDown only; detector keeps tracking phase
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cpUp <= 1'b0;
         cpDown <= 1'b0;
         div_compare_pulse <= 1'b0;
         refComparePulse <= 1'b0;
      end else if (ce) begin
         cpUp <= pfdUp && refCfg[plld_pkg::CPEN_BIT];
         cpDown <= pfdDown && refCfg[plld_pkg::CPEN_BIT];
         div_compare_pulse <= refCfg[plld_pkg::SENSE_BIT] ? refEnd : endCycle;
         refComparePulse <= refCfg[plld_pkg::SENSE_BIT] ? endCycle : refEnd;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n || !ce);

   sequence cycleEnd_s;
      endCycle;
   endsequence

   sequence swallowPhase_s;
      psPulse && !swallowDone && !endCycle;
   endsequence

   sequence restart_s;
      cycleEnd_s ##1 (activeA != '0);
   endsequence

   sequence cpGated_s;
      !refCfg[plld_pkg::CPEN_BIT];
   endsequence

   cycle_reset_a: assert property (cycleEnd_s |=>
      swCnt == '0 && mainCnt == '0)
      else $error("counters not reset at end of cycle");
   swallow_count_a: assert property (swallowPhase_s |=>
      swCnt == $past(swCnt) + 1'b1)
      else $error("swallow counter did not advance");
   small_mod_a: assert property (swallowDone &&
      refCfg[plld_pkg::MODSEL_BIT] |-> psLast == plld_pkg::MOD8_LAST)
      else $error("wrong prescaler modulus after swallow");
   large_mod_a: assert property (!swallowDone &&
      !refCfg[plld_pkg::MODSEL_BIT] |->
      psLast == plld_pkg::MOD16_LAST + 5'h01)
      else $error("wrong large prescaler modulus");
   main_bound_a: assert property (activeM != '0 &&
      mainCnt < activeM && !(remaining > plld_pkg::MAIN_GUARD) |=>
      $stable(activeM))
      else $error("divider word changed near end of count");
   ref_wrap_a: assert property (refEnd |=> refCnt == '0)
      else $error("reference divider not restarted");
   apb_answer_a: assert property (setupPh |=> pready)
      else $error("register access not answered");
   // New cycle must start at the larger modulus
   psc_restart_a: assert property (restart_s |-> !swallowDone)
      else $error("prescaler not back at larger modulus");
   psc_wrap_a: assert property (psPulse |=> psCnt == '0)
      else $error("prescaler not restarted after its pulse");
   ref_reload_a: assert property (refEnd |=>
      refBuf == $past(refCfg[plld_pkg::RATIO_LSB +: REF_W]))
      else $error("reference buffer not reloaded");
   // Output stage: gating of the charge pump controls and routing of the divided pulses
   cp_gate_a: assert property (cpGated_s |=> !cpUp && !cpDown)
      else $error("charge pump controls not gated off");
   cp_follow_a: assert property (refCfg[plld_pkg::CPEN_BIT] |=>
      cpUp == $past(pfdUp) && cpDown == $past(pfdDown))
      else $error("charge pump controls do not follow detector");
   cmp_plain_a: assert property (!refCfg[plld_pkg::SENSE_BIT] |=>
      div_compare_pulse == $past(endCycle) &&
      refComparePulse == $past(refEnd))
      else $error("compare pulses misrouted");
   cmp_swap_a: assert property (refCfg[plld_pkg::SENSE_BIT] |=>
      div_compare_pulse == $past(refEnd) &&
      refComparePulse == $past(endCycle))
      else $error("compare pulses not swapped");
endmodule : plld_top
`default_nettype wire

// File: plld_pkg.sv
`default_nettype none
package plld_pkg;
   // Register byte addresses
   localparam logic [7:0] ADDR_WORD1 = 8'h00;
   localparam logic [7:0] ADDR_WORD2 = 8'h04;
   localparam logic [7:0] ADDR_REFCFG = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   // Divider word fields
   localparam int SWALLOW_W = 4;
   localparam int MAIN_W = 15;
   localparam int REF_W = 13;
   localparam int SWALLOW_LSB = 0;
   localparam int MAIN_LSB = 4;
   // Reference configuration fields
   localparam int RATIO_LSB = 0;
   localparam int MODSEL_BIT = 13;
   localparam int SENSE_BIT = 14;
   localparam int CPEN_BIT = 15;
   // Status fields
   localparam int STAT_MAIN_LSB = 0;
   localparam int STAT_SWALLOW_LSB = 16;
   localparam int STAT_SMALLMOD_BIT = 20;
   // Prescaler moduli, minus one
   localparam logic [4:0] MOD8_LAST = 5'h07;
   localparam logic [4:0] MOD16_LAST = 5'h0F;
   // Reload guard threshold
   localparam logic [14:0] MAIN_GUARD = 15'h0003;
   // Reset values
   localparam logic [31:0] WORD_RST = 32'h0000_0000;
   localparam logic [31:0] REFCFG_RST = 32'h0000_8001;
endpackage : plld_pkg
`default_nettype wire

// File: plld_pfd.sv
`default_nettype none
module plld_pfd (
   // Clocking
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // Divided pulses
   input wire logic divPulse,
   input wire logic refPulse,
   input wire logic sense,
   // Detector state
   output logic up,
   output logic down
);
   logic setUp;
   logic setDown;

   // Sense swaps which pulse sets which flip-flop
   assign setUp = sense ? divPulse : refPulse;
   assign setDown = sense ? refPulse : divPulse;

   // Both set: cleared next edge, a one-cycle overlap keeps gain
   // linear through zero phase; a new set wins over the clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         up <= 1'b0;
         down <= 1'b0;
      end else if (ce) begin
         up <= ((up && down) ? 1'b0 : up) | setUp;
         down <= ((up && down) ? 1'b0 : down) | setDown;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n || !ce);

   sequence bothSet_s;
      up && down && !setUp && !setDown;
   endsequence

   pfd_clear_a: assert property (bothSet_s |=> !up && !down)
      else $error("detector not cleared after both set");
   pfd_set_a: assert property (setUp |=> up)
      else $error("up flip-flop not set by its pulse");
   pfd_swap_a: assert property (sense && divPulse |=> up)
      else $error("sense swap not applied");
endmodule : plld_pfd
`default_nettype wire

// File: plld_vco.sv
`default_nettype none
module plld_vco (
   // Clocking
   input wire logic clock,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic [1:0] half,
   // Divided VCO output
   output logic rfIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt;
   // Stands low when stopped; each rising edge keeps a low sample before it
   always_ff @(posedge clock) begin
      if (!rst_n || !run) begin
         cnt <= 2'h0;
         rfIn <= 1'b0;
      end else if (cnt == half - 2'h1) begin
         cnt <= 2'h0;
         rfIn <= ~rfIn;
      end else begin
         cnt <= cnt + 2'h1;
      end
   end
endmodule : plld_vco
`default_nettype wire

// File: plld_tb_top.sv
`default_nettype none
module plld_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic modsel;
      logic [1:0] half;
      logic [3:0] a;
      logic [14:0] m;
      logic [12:0] r;
   } plld_row_t;
   // Model run is about 52k cycles, mostly the 8191 reference row and the row after it
   localparam int LIMIT = 60000;
   // Main count kept at least swallow, swallow MSB zero at 8/9
   localparam plld_row_t ROWS [5] = '{
      '{1'h1, 2'h1, 4'h0, 15'h0007, 13'h0001},
      '{1'h1, 2'h1, 4'h7, 15'h0007, 13'h0003},
      '{1'h0, 2'h1, 4'hF, 15'h000F, 13'h1FFF},
      '{1'h0, 2'h2, 4'h1, 15'h0005, 13'h0005},
      '{1'h0, 2'h1, 4'h2, 15'h0005, 13'h000D}};
   logic clock, rst_n, psel, penable, pwrite, pready, pslverr, run, ce;
   logic word_select, rfIn, cpUp, cpDown, div_compare_pulse, refCmp;
   logic refIn = 1'h0;
   logic [1:0] half;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic e;
   int failures = 0, n_checks = 0, cycles = 0, nn, u0, d0, du0, dd0;
   int divCnt = 0, divLast = 0, divSeen = 0, upCnt = 0, dnCnt = 0;
   int refCnt = 0, refLast = 0, refSeen = 0;
   plld_top plld_top_inst (.clock(clock), .rst_n(rst_n), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rfIn(rfIn), .refIn(refIn),
      .word_select(word_select), .cpUp(cpUp), .cpDown(cpDown),
      .div_compare_pulse(div_compare_pulse), .refComparePulse(refCmp));
   plld_vco plld_vco_inst (.clock(clock), .rst_n(rst_n), .run(run),
      .half(half), .rfIn(rfIn));
   initial begin
      clock = 1'h0;
      forever #50 clock = ~clock;
   end
   // Interval monitors count cycles between compare pulses
   always @(posedge clock) begin
      refIn <= ~refIn;
      // Unknown levels count as active so a gated check catches them
      upCnt <= upCnt + ((cpUp !== 1'h0) ? 1 : 0);
      dnCnt <= dnCnt + ((cpDown !== 1'h0) ? 1 : 0);
      divCnt <= (div_compare_pulse === 1'h1) ? 1 : divCnt + 1;
      refCnt <= (refCmp === 1'h1) ? 1 : refCnt + 1;
      if (div_compare_pulse === 1'h1) begin
         divLast <= divCnt;
         divSeen <= divSeen + 1;
      end
      if (refCmp === 1'h1) begin
         refLast <= refCnt;
         refSeen <= refSeen + 1;
      end
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         failures++;
         $display("MISMATCH %0t timeout", $time);
         stop_test();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clock);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do @(posedge clock); while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chkVal
   task automatic waitN(input logic sel, input int n);
      int s;
      s = sel ? refSeen : divSeen;
      while ((sel ? refSeen : divSeen) < s + n) @(posedge clock);
   endtask : waitN
   task automatic stop_test();
      if (failures == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   initial begin
      rst_n = 1'h0;
      ce = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      word_select = 1'h1;
      run = 1'h0;
      half = 2'h1;
      repeat (4) @(posedge clock);
      rst_n <= 1'h1;
      apb(1'h0, plld_pkg::ADDR_REFCFG, 32'h0);
      chkVal(q, plld_pkg::REFCFG_RST);
      run <= 1'h1;
      foreach (ROWS[i]) begin
         nn = ROWS[i].modsel ? 8 : 16;
         half <= ROWS[i].half;
         apb(1'h1, plld_pkg::ADDR_WORD1, {13'h0, ROWS[i].m, ROWS[i].a});
         apb(1'h1, plld_pkg::ADDR_REFCFG,
            {16'h0, 2'h2, ROWS[i].modsel, ROWS[i].r});
         waitN(1'h0, 3);
         waitN(1'h1, 2);
         nn = (ROWS[i].m * nn + ROWS[i].a) * 2 * ROWS[i].half;
         chkVal(divLast, nn);
         chkVal(refLast, ROWS[i].r * 2);
         apb(1'h0, plld_pkg::ADDR_WORD1, 32'h0);
         chkVal(q, {13'h0, ROWS[i].m, ROWS[i].a});
      end
      // Second word picked by the select level while more than MAIN_GUARD main counts remain
      apb(1'h1, plld_pkg::ADDR_WORD2, {13'h0, 15'h0006, 4'h3});
      word_select <= 1'h0;
      waitN(1'h0, 3);
      chkVal(divLast, 99 * 2);
      u0 = upCnt;
      d0 = dnCnt;
      waitN(1'h0, 2);
      du0 = upCnt - u0;
      dd0 = dnCnt - d0;
      apb(1'h1, plld_pkg::ADDR_REFCFG, {16'h0, 3'h6, 13'h000D});
      waitN(1'h1, 3);
      chkVal(divLast, 13 * 2);
      chkVal(refLast, 99 * 2);
      u0 = upCnt;
      d0 = dnCnt;
      waitN(1'h1, 2);
      e = (du0 > dd0) ^ (upCnt - u0 > dnCnt - d0);
      chkVal({31'h0, e}, 32'h1);
      // Enable low must hold every output; div_compare_pulse runs at 26, refComparePulse at 198
      ce <= 1'h0;
      @(posedge clock);
      q = {28'h0, cpUp, cpDown, div_compare_pulse, refCmp};
      nn = 0;
      repeat (30) begin
         @(posedge clock);
         if ({cpUp, cpDown, div_compare_pulse, refCmp} !== q[3:0]) begin
            nn++;
         end
      end
      ce <= 1'h1;
      chkVal(nn, 32'h0);
      apb(1'h1, plld_pkg::ADDR_REFCFG, {16'h0, 3'h0, 13'h000D});
      waitN(1'h1, 1);
      u0 = upCnt + dnCnt;
      waitN(1'h1, 2);
      chkVal(upCnt + dnCnt - u0, 32'h0);
      rst_n <= 1'h0;
      repeat (4) @(posedge clock);
      rst_n <= 1'h1;
      @(posedge clock);
      chkVal({cpUp, cpDown, div_compare_pulse, refCmp}, 32'h0);
      apb(1'h0, plld_pkg::ADDR_WORD2, 32'h0);
      chkVal(q, plld_pkg::WORD_RST);
      apb(1'h1, 8'h10, 32'hFFFF_FFFF);
      chkVal({31'h0, e}, 32'h1);
      // Status is read only; stopped divider sits at modulus N
      apb(1'h1, plld_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
      chkVal({31'h0, e}, 32'h0);
      apb(1'h0, plld_pkg::ADDR_STATUS, 32'h0);
      chkVal(q, 32'h1 << plld_pkg::STAT_SMALLMOD_BIT);
      stop_test();
   end
endmodule : plld_tb_top
`default_nettype wire
